// ---- csfr_pkg.sv ----
// Purpose: Offsets, field positions and reset values of the charger
//          status and event flag registers.
// Assumes: Byte-wide registers addressed by their printed offsets.
// Notes: Status registers have no reset value; flags reset to zero.
package csfr_pkg;
  localparam logic [7:0] OFF_CHARGE_STATUS = 8'h00;
  localparam logic [7:0] OFF_FAULT_STATUS = 8'h01;
  localparam logic [7:0] OFF_ALARM_STATUS = 8'h02;
  localparam logic [7:0] OFF_CHARGE_FLAGS = 8'h03;
  localparam logic [7:0] OFF_FAULT_FLAGS = 8'h04;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  // Charge status and charge flag bit positions
  localparam int BIT_TAPER = 6;
  localparam int BIT_DONE = 5;
  localparam int BIT_INLIM = 4;
  localparam int BIT_PATH = 3;
  localparam int BIT_VINREG = 2;
  localparam int BIT_THERM = 1;
  localparam int BIT_PGOOD = 0;
  // Fault status and fault flag bit positions
  localparam int BIT_OVP = 7;
  localparam int BIT_OCP = 5;
  localparam int BIT_BATLOW = 4;
  localparam int BIT_COLD = 3;
  localparam int BIT_COOL = 2;
  localparam int BIT_WARM = 1;
  localparam int BIT_HOT = 0;
  // Alarm status bit positions
  localparam int BIT_CMP1 = 6;
  localparam int BIT_CMP2 = 5;
  localparam int BIT_CMP3 = 4;
  localparam int BIT_TSOPEN = 0;
  // Valid bits of each register; the rest read as zero
  localparam logic [7:0] MASK_CHARGE = 8'h7f;
  localparam logic [7:0] MASK_FAULT = 8'hbf;
  localparam logic [7:0] MASK_ALARM = 8'h71;
endpackage

// ---- csfr_regs.sv ----
// Purpose: Live status views and clear-on-read event flags of a charger.
// Assumes: Live inputs come from analog comparators, asynchronous to clk.
//          Read strobe comes from the I2C slave on the same clock.
// Notes: Read data is registered; the clear acts on the strobe cycle.
`timescale 1ns/1ps

module csfr_regs (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic taper_phase_live_in,
  input wire logic charge_done_live_in,
  input wire logic input_limit_live_in,
  input wire logic path_regulation_live_in,
  input wire logic input_voltage_reg_live_in,
  input wire logic die_thermal_live_in,
  input wire logic input_above_uvlo_in,
  input wire logic input_above_sleep_in,
  input wire logic input_below_ovp_in,
  input wire logic input_overvoltage_live_in,
  input wire logic battery_overcurrent_live_in,
  input wire logic battery_low_live_in,
  input wire logic therm_cold_live_in,
  input wire logic therm_cool_live_in,
  input wire logic therm_warm_live_in,
  input wire logic therm_hot_live_in,
  input wire logic therm_open_live_in,
  input wire logic compare_one_live_in,
  input wire logic compare_two_live_in,
  input wire logic compare_three_live_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_read_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] charge_event_flags_out,
  output logic [7:0] fault_event_flags_out
);

  localparam int NLIVE = 21;

  logic [NLIVE-1:0] raw;
  logic [NLIVE-1:0] sync1;
  logic [NLIVE-1:0] sync2;
  logic [NLIVE-1:0] sync3;
  logic [NLIVE-1:0] live;
  logic [7:0] charge_status;
  logic [7:0] fault_temp_status;
  logic [7:0] alarm_status;
  logic [7:0] charge_event_flags;
  logic [7:0] fault_event_flags;
  logic [7:0] prev_charge;
  logic [7:0] prev_fault;
  logic [7:0] charge_set;
  logic [7:0] fault_set;
  logic [7:0] next_charge_flags;
  logic [7:0] next_fault_flags;
  logic read_charge_flags;
  logic read_fault_flags;
  logic in_good_raw;

  assign in_good_raw = input_above_uvlo_in & input_above_sleep_in &
                       input_below_ovp_in;

  // Gather live inputs in one vector for the synchroniser
  assign raw = {compare_three_live_in, compare_two_live_in,
                compare_one_live_in, therm_open_live_in,
                therm_hot_live_in, therm_warm_live_in, therm_cool_live_in,
                therm_cold_live_in, battery_low_live_in,
                battery_overcurrent_live_in, input_overvoltage_live_in,
                in_good_raw, die_thermal_live_in, input_voltage_reg_live_in,
                path_regulation_live_in, input_limit_live_in,
                charge_done_live_in, taper_phase_live_in, 3'h0};

  // Three stages; the second is read only by the third and the filter
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A change counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < NLIVE; gi++) begin : g_filt
      always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          live[gi] <= 1'b0;
        end else if (sync2[gi] == sync3[gi]) begin
          live[gi] <= sync3[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    charge_status = 8'h00;
    charge_status[csfr_pkg::BIT_TAPER] = live[3];
    charge_status[csfr_pkg::BIT_DONE] = live[4];
    charge_status[csfr_pkg::BIT_INLIM] = live[5];
    charge_status[csfr_pkg::BIT_PATH] = live[6];
    charge_status[csfr_pkg::BIT_VINREG] = live[7];
    charge_status[csfr_pkg::BIT_THERM] = live[8];
    charge_status[csfr_pkg::BIT_PGOOD] = live[9];
  end

  always_comb begin
    fault_temp_status = 8'h00;
    fault_temp_status[csfr_pkg::BIT_OVP] = live[10];
    fault_temp_status[csfr_pkg::BIT_OCP] = live[11];
    fault_temp_status[csfr_pkg::BIT_BATLOW] = live[12];
    fault_temp_status[csfr_pkg::BIT_COLD] = live[13];
    fault_temp_status[csfr_pkg::BIT_COOL] = live[14];
    fault_temp_status[csfr_pkg::BIT_WARM] = live[15];
    fault_temp_status[csfr_pkg::BIT_HOT] = live[16];
  end

  always_comb begin
    alarm_status = 8'h00;
    alarm_status[csfr_pkg::BIT_CMP1] = live[18];
    alarm_status[csfr_pkg::BIT_CMP2] = live[19];
    alarm_status[csfr_pkg::BIT_CMP3] = live[20];
    alarm_status[csfr_pkg::BIT_TSOPEN] = live[17];
  end

  // Previous views for entry detection
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev_charge <= 8'h00;
      prev_fault <= 8'h00;
    end else begin
      prev_charge <= charge_status;
      prev_fault <= fault_temp_status;
    end
  end

  always_comb begin
    charge_set = charge_status & ~prev_charge & csfr_pkg::MASK_CHARGE;
    charge_set[csfr_pkg::BIT_PGOOD] = charge_status[csfr_pkg::BIT_PGOOD] ^
                                      prev_charge[csfr_pkg::BIT_PGOOD];
  end

  assign fault_set = fault_temp_status & ~prev_fault & csfr_pkg::MASK_FAULT;

  assign read_charge_flags = reg_read_in &&
                             reg_addr_in == csfr_pkg::OFF_CHARGE_FLAGS;
  assign read_fault_flags = reg_read_in &&
                            reg_addr_in == csfr_pkg::OFF_FAULT_FLAGS;

  // read clears, but a same-cycle set wins
  assign next_charge_flags = (read_charge_flags ? 8'h00 : charge_event_flags)
                             | charge_set;
  assign next_fault_flags = (read_fault_flags ? 8'h00 : fault_event_flags)
                            | fault_set;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      charge_event_flags <= csfr_pkg::FLAG_RESET;
      fault_event_flags <= csfr_pkg::FLAG_RESET;
    end else begin
      charge_event_flags <= next_charge_flags;
      fault_event_flags <= next_fault_flags;
    end
  end

  assign charge_event_flags_out = charge_event_flags;
  assign fault_event_flags_out = fault_event_flags;

  // read mux; writes change nothing, unmapped reads zero
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      case (reg_addr_in)
        csfr_pkg::OFF_CHARGE_STATUS: reg_rdata_out <= charge_status;
        csfr_pkg::OFF_FAULT_STATUS: reg_rdata_out <= fault_temp_status;
        csfr_pkg::OFF_ALARM_STATUS: reg_rdata_out <= alarm_status;
        csfr_pkg::OFF_CHARGE_FLAGS: reg_rdata_out <= charge_event_flags;
        csfr_pkg::OFF_FAULT_FLAGS: reg_rdata_out <= fault_event_flags;
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // Checks
  sequence s_taper_rise;
    !charge_status[csfr_pkg::BIT_TAPER] ##1
      charge_status[csfr_pkg::BIT_TAPER];
  endsequence

  a_taper_latch: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    s_taper_rise |=> charge_event_flags[csfr_pkg::BIT_TAPER])
    else $error("taper entry not latched");

  a_pgood_change: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    $changed(charge_status[csfr_pkg::BIT_PGOOD]) |=>
      charge_event_flags[csfr_pkg::BIT_PGOOD])
    else $error("power good change not latched");

  a_read_clears: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    read_charge_flags && charge_set == 8'h00 |=>
      charge_event_flags == 8'h00)
    else $error("charge flags not cleared by read");

  a_set_wins: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    read_fault_flags && fault_set != 8'h00 |=>
      (fault_event_flags & $past(fault_set)) == $past(fault_set))
    else $error("event lost on clearing read");

  a_flag_hold: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    charge_event_flags[csfr_pkg::BIT_DONE] && !read_charge_flags |=>
      charge_event_flags[csfr_pkg::BIT_DONE])
    else $error("done flag dropped without read");

  a_reserved_zero: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    (charge_event_flags & ~csfr_pkg::MASK_CHARGE) == 8'h00 &&
    (fault_event_flags & ~csfr_pkg::MASK_FAULT) == 8'h00)
    else $error("reserved flag bit set");

  a_pgood_all: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !in_good_raw [*6] |-> !charge_status[csfr_pkg::BIT_PGOOD])
    else $error("power good without all conditions");

  a_cold_entry: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    $rose(fault_temp_status[csfr_pkg::BIT_COLD]) |=>
      fault_event_flags[csfr_pkg::BIT_COLD])
    else $error("cold entry not latched");

  a_status_read: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    reg_read_in && reg_addr_in == csfr_pkg::OFF_FAULT_STATUS |=>
      reg_rdata_out == $past(fault_temp_status))
    else $error("fault status read mismatch");

  // Five steady samples cover three stages plus the agreement filter
  a_done_follow: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    charge_done_live_in [*5] |-> charge_status[csfr_pkg::BIT_DONE])
    else $error("done status not following input");

  a_taper_drop: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    !taper_phase_live_in [*5] |-> !charge_status[csfr_pkg::BIT_TAPER])
    else $error("taper status stuck high");

  a_battery_low_follow: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    battery_low_live_in [*5] |-> fault_temp_status[csfr_pkg::BIT_BATLOW])
    else $error("battery low status not following input");

  a_compare_follow: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    compare_one_live_in [*5] |-> alarm_status[csfr_pkg::BIT_CMP1])
    else $error("comparator one status not following input");

  a_limit_latch: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    $rose(charge_status[csfr_pkg::BIT_INLIM]) |=>
      charge_event_flags[csfr_pkg::BIT_INLIM])
    else $error("input limit entry not latched");

  // A write may neither clear nor set a flag; only events and reads do
  a_write_ignored: assert property (
    @(posedge clk_sys_in) disable iff (sys_rst_in)
    reg_write_in && !reg_read_in |=>
      charge_event_flags ==
        ($past(charge_event_flags) | $past(charge_set)) &&
      fault_event_flags == ($past(fault_event_flags) | $past(fault_set)))
    else $error("write changed a flag register");

endmodule

// ---- csfr_host_model.sv ----
// Purpose: Host side model that reads and writes the status registers.
// Assumes: Strobes change at the falling edge, taken at the rising edge.
// Notes: Address is inverted after a read, write data after a write, so stale values never match.
`timescale 1ns/1ps
module csfr_host_model (
  input wire logic clk_sys_in,
  output logic [7:0] reg_addr_out,
  output logic reg_read_out,
  output logic reg_write_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  // Idle bus at time zero
  initial begin
    reg_addr_out = 8'hff;
    reg_read_out = 1'b0;
    reg_write_out = 1'b0;
    reg_wdata_out = 8'h00;
  end

  // One-cycle strobe; data sampled a full cycle later, where it stands
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_sys_in);
    reg_addr_out = addr;
    reg_read_out = 1'b1;
    @(negedge clk_sys_in);
    reg_read_out = 1'b0;
    reg_addr_out = ~addr;
    @(negedge clk_sys_in);
    data = reg_rdata_in;
  endtask

  // Write strobe; the block is expected to ignore it
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] wd);
    @(negedge clk_sys_in);
    reg_addr_out = addr;
    reg_wdata_out = wd;
    reg_write_out = 1'b1;
    @(negedge clk_sys_in);
    reg_write_out = 1'b0;
    reg_wdata_out = ~wd;
  endtask
endmodule

// ---- tb_charger_status_flag_regs.sv ----
// Purpose: Self-checking bench for the status and event flag registers.
// Assumes: Live inputs need 4 edges to show, flags one edge more.
// Notes: Waits of 8 cycles give margin over that latency.
`timescale 1ns/1ps
module tb_charger_status_flag_regs;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [6:0] chg = 7'h00;
  logic [2:0] pg = 3'h0;
  logic [7:0] flt = 8'h00;
  logic [7:0] alm = 8'h00;
  logic [7:0] addr, wd, rd, cflags, fflags, r1, r2, r3;
  logic rdst, wrst, good, prev;
  int error_cnt = 0;
  int check_count = 0;

  // Free-running 40 MHz clock
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  csfr_host_model u_csfr_host_model (.clk_sys_in(clk_sys_in),
    .reg_addr_out(addr), .reg_read_out(rdst), .reg_write_out(wrst),
    .reg_wdata_out(wd), .reg_rdata_in(rd));

  csfr_regs u_csfr_regs (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .taper_phase_live_in(chg[6]), .charge_done_live_in(chg[5]),
    .input_limit_live_in(chg[4]), .path_regulation_live_in(chg[3]),
    .input_voltage_reg_live_in(chg[2]), .die_thermal_live_in(chg[1]),
    .input_above_uvlo_in(pg[0]), .input_above_sleep_in(pg[1]),
    .input_below_ovp_in(pg[2]), .input_overvoltage_live_in(flt[7]),
    .battery_overcurrent_live_in(flt[5]), .battery_low_live_in(flt[4]),
    .therm_cold_live_in(flt[3]), .therm_cool_live_in(flt[2]),
    .therm_warm_live_in(flt[1]), .therm_hot_live_in(flt[0]),
    .therm_open_live_in(alm[0]), .compare_one_live_in(alm[6]),
    .compare_two_live_in(alm[5]), .compare_three_live_in(alm[4]),
    .reg_addr_in(addr), .reg_read_in(rdst), .reg_write_in(wrst),
    .reg_wdata_in(wd), .reg_rdata_out(rd),
    .charge_event_flags_out(cflags), .fault_event_flags_out(fflags));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_csfr_host_model.read_reg(a, d);
    check(d, exp);
  endtask

  // Long enough for a live change to reach status and flags
  task automatic settle;
    repeat (8) @(negedge clk_sys_in);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    repeat (10) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    rd_chk(csfr_pkg::OFF_CHARGE_FLAGS, csfr_pkg::FLAG_RESET);
    rd_chk(csfr_pkg::OFF_FAULT_FLAGS, csfr_pkg::FLAG_RESET);
    // Each charge condition alone: live bit, latched flag, clear on read
    for (int i = 1; i < 7; i++) begin
      chg = 7'(1 << i);
      settle();
      rd_chk(csfr_pkg::OFF_CHARGE_STATUS, 8'(1 << i));
      check(cflags, 8'(1 << i));
      rd_chk(csfr_pkg::OFF_CHARGE_FLAGS, 8'(1 << i));
      rd_chk(csfr_pkg::OFF_CHARGE_FLAGS, 8'h00);
      chg = 7'h00;
      settle();
      u_csfr_host_model.read_reg(csfr_pkg::OFF_CHARGE_FLAGS, r1);
    end
    // Power good needs all three; the flag marks every change of it
    prev = 1'b0;
    for (int k = 0; k < 9; k++) begin
      pg = 3'(k);
      settle();
      good = (k == 7);
      rd_chk(csfr_pkg::OFF_CHARGE_STATUS, {7'h00, good});
      rd_chk(csfr_pkg::OFF_CHARGE_FLAGS, {7'h00, good != prev});
      prev = good;
    end
    // Faults and thermistor regions; bit 6 has no source
    for (int i = 0; i < 8; i++) begin
      if (i != 6) begin
        flt = 8'(1 << i);
        settle();
        rd_chk(csfr_pkg::OFF_FAULT_STATUS, 8'(1 << i));
        check(fflags, 8'(1 << i));
        rd_chk(csfr_pkg::OFF_FAULT_FLAGS, 8'(1 << i));
        rd_chk(csfr_pkg::OFF_FAULT_FLAGS, 8'h00);
        flt = 8'h00;
        settle();
        rd_chk(csfr_pkg::OFF_FAULT_FLAGS, 8'h00);
      end
    end
    // Comparator and open thermistor alarms; reserved positions stay zero
    for (int i = 0; i < 8; i++) begin
      alm = 8'(1 << i);
      settle();
      rd_chk(csfr_pkg::OFF_ALARM_STATUS, 8'h71 & 8'(1 << i));
    end
    alm = 8'h00;
    // Writes change nothing; unmapped offset reads zero
    flt = 8'hbf;
    settle();
    u_csfr_host_model.read_reg(csfr_pkg::OFF_FAULT_FLAGS, r1);
    u_csfr_host_model.write_reg(csfr_pkg::OFF_FAULT_STATUS, 8'h00);
    rd_chk(csfr_pkg::OFF_FAULT_STATUS, 8'hbf);
    u_csfr_host_model.write_reg(csfr_pkg::OFF_CHARGE_FLAGS, 8'hff);
    rd_chk(csfr_pkg::OFF_CHARGE_FLAGS, 8'h00);
    rd_chk(8'h05, 8'h00);
    flt = 8'h00;
    // Sweep event arrival across the clearing read; it must not vanish
    for (int d = 0; d < 8; d++) begin
      chg = 7'h40;
      repeat (d) @(negedge clk_sys_in);
      u_csfr_host_model.read_reg(csfr_pkg::OFF_CHARGE_FLAGS, r1);
      u_csfr_host_model.read_reg(csfr_pkg::OFF_CHARGE_FLAGS, r2);
      // A set on the read edge shows only in the read after it
      u_csfr_host_model.read_reg(csfr_pkg::OFF_CHARGE_FLAGS, r3);
      check(8'(r1[6]) + 8'(r2[6]) + 8'(r3[6]), 8'h01);
      chg = 7'h00;
      settle();
      u_csfr_host_model.read_reg(csfr_pkg::OFF_CHARGE_FLAGS, r1);
    end
    report_and_stop();
  end
endmodule
